// ### rtl/ssp_pkg.sv
/*
 Package for the serial slave frame port: frame length constants, reset values and the receive state enumeration.
 Assumes a 40 MHz system clock and a master shift clock of at most 5 MHz.
*/
package ssp_pkg;
   // Width of one device frame in bits.
   localparam int unsigned SSP_FRAME_BITS = 16;
   // Extra groups beyond the first frame must be whole multiples of this count.
   localparam int unsigned SSP_GROUP_BITS = 8;
   // Width of the clock pulse counter; long chains wrap modulo 256.
   localparam int unsigned SSP_CNT_W = 8;
   // Reset value of the transmission error flag.
   localparam logic SSP_TXERR_RST = 1'b0;
   // Response word shifted out in the first frame after reset.
   localparam logic [15:0] SSP_FIRST_RESP = 16'h0000;
   // Frame receive states.
   typedef enum logic [1:0] {
      SSP_IDLE = 2'b00,
      SSP_SHIFT = 2'b01,
      SSP_SLEEP = 2'b10
   } ssp_state_type;
endpackage

// ### rtl/ssp_frame_port.sv
/*
 Serial slave frame port: oversamples chip select, shift clock and serial input and exchanges frames MSB first.
 Assumes the master keeps the shift clock low at every chip select edge and a shift clock of at most 5 MHz.
*/
// Notes on behaviour
// - Select fall starts access; exchange while low.
// - Sample on clock fall, drive on rise.
// - Accept 16 plus multiple of 8 pulses.
// - Bad length sets error, discards command.
// - Select high: ignore inputs, output floats.
// - Select fall loads requested response.
// - First output is error OR serial input.
// - Sleep keeps output floating, no transfer.
// - Valid frame end copies shift register out.
// - Frames MSB first, control then data.
// - Response shifted out MSB first on rises.
// - One shift register, 16 clocks per device.
// - Answer comes in the next transfer.
// - First frame after reset is a fixed response.
`timescale 1ns/1ps
`default_nettype none
module ssp_frame_port
   import ssp_pkg::*;
#(
   parameter int unsigned FRAME_BITS = SSP_FRAME_BITS
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic chip_select_low_i,
   input wire logic sclk_i,
   input wire logic si_i,
   input wire logic sleep_i,
   input wire logic [15:0] resp_word_i,
   input wire logic sw_reset_i,
   output logic so_o,
   output logic so_oe_o,
   output logic [15:0] frame_data_o,
   output logic frame_valid_o,
   output logic frame_error_o,
   output logic resp_load_o,
   output logic transmission_error_flag_o
);
   // The shift register width is fixed by the frame format.
   initial begin
      if (FRAME_BITS != 16) begin
         $error("FRAME_BITS must be 16");
      end
   end
   // Synchroniser stages; the first stage is read only by the second.
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   // Previous synchronised levels for edge detection.
   logic cs_d;
   logic sck_d;
   // Receive state, shift register, pulse count, error flag and output bit.
   ssp_state_type state;
   ssp_state_type next_state;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic [SSP_CNT_W-1:0] cnt;
   logic [SSP_CNT_W-1:0] next_cnt;
   // Transmission error flag: set by a bad length, cleared by a good frame.
   logic tx_err;
   // Next value of the transmission error flag.
   logic next_tx_err;
   logic so_bit;
   logic next_so_bit;
   logic first;
   logic next_first;
   logic [15:0] dout;
   logic [15:0] next_dout;
   logic vld;
   logic next_vld;
   logic err;
   logic next_err;
   logic ld;
   logic next_ld;
   // Synchronised levels and edges.
   logic cs_s;
   logic sck_s;
   logic si_s;
   logic cs_fall;
   logic cs_rise;
   logic sck_fall;
   logic sck_rise;
   logic len_ok;

   // Two flip-flop synchronisers for all pin inputs.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         // Idle pin levels: select high, clock low, data low, so no false edge follows reset.
         sync_a <= 3'h4;
         sync_b <= 3'h4;
         cs_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         sync_a <= {chip_select_low_i, sclk_i, si_i};
         sync_b <= sync_a;
         cs_d <= sync_b[2];
         sck_d <= sync_b[1];
      end
   end

   assign cs_s = sync_b[2];
   assign sck_s = sync_b[1];
   assign si_s = sync_b[0];
   // Edges of the select line and of the shift clock.
   assign cs_fall = cs_d & ~cs_s;
   assign cs_rise = ~cs_d & cs_s;
   assign sck_fall = sck_d & ~sck_s;
   assign sck_rise = ~sck_d & sck_s;
   // Length check: at least 16 and a whole number of bytes.
   assign len_ok = (cnt >= SSP_CNT_W'(FRAME_BITS)) && (cnt[2:0] == 3'h0);

   // Next state of the receive machine and its datapath.
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_cnt = cnt;
      next_tx_err = tx_err;
      next_so_bit = so_bit;
      next_first = first;
      next_dout = dout;
      next_vld = 1'b0;
      next_err = 1'b0;
      next_ld = 1'b0;
      case (state)
         SSP_IDLE: begin
            // Outside a frame clock and data are ignored.
            if (cs_fall) begin
               if (sleep_i) begin
                  next_state = SSP_SLEEP;
               end else begin
                  next_state = SSP_SHIFT;
                  next_cnt = '0;
                  next_ld = 1'b1;
                  // Response of the previous command, or the fixed word after reset.
                  next_shreg = first ? SSP_FIRST_RESP : resp_word_i;
                  next_first = 1'b0;
               end
            end
         end
         SSP_SHIFT: begin
            if (cs_rise) begin
               next_state = SSP_IDLE;
               if (len_ok) begin
                  // Last 16 bits received are handed on.
                  next_dout = shreg;
                  next_vld = 1'b1;
                  next_tx_err = 1'b0;
               end else begin
                  next_tx_err = 1'b1;
                  next_err = 1'b1;
               end
            end else if (sck_fall) begin
               // Serial input enters at the bottom; MSB leaves first.
               next_shreg = {shreg[14:0], si_s};
               next_cnt = cnt + 1'b1;
            end else if (sck_rise) begin
               next_so_bit = shreg[15];
            end
         end
         SSP_SLEEP: begin
            if (cs_rise) begin
               next_state = SSP_IDLE;
            end
         end
         default: begin
            next_state = SSP_IDLE;
         end
      endcase
      // A software reset wins over the load that clears the marker in the same cycle.
      if (sw_reset_i) begin
         next_first = 1'b1;
      end
      // First bit after select falls is error OR serial input.
      if (state == SSP_IDLE && cs_fall && !sleep_i) begin
         next_so_bit = tx_err | si_s;
      end
   end

   // Registers of the receive machine.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state <= SSP_IDLE;
         shreg <= 16'h0000;
         cnt <= '0;
         tx_err <= SSP_TXERR_RST;
         so_bit <= 1'b0;
         first <= 1'b1;
         dout <= 16'h0000;
         vld <= 1'b0;
         err <= 1'b0;
         ld <= 1'b0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         cnt <= next_cnt;
         tx_err <= next_tx_err;
         so_bit <= next_so_bit;
         first <= next_first;
         dout <= next_dout;
         vld <= next_vld;
         err <= next_err;
         ld <= next_ld;
      end
   end

   // Output drives only during an active, non-sleep frame.
   assign so_oe_o = (state == SSP_SHIFT);
   assign so_o = so_bit;
   assign frame_data_o = dout;
   assign frame_valid_o = vld;
   assign frame_error_o = err;
   assign resp_load_o = ld;
   assign transmission_error_flag_o = tx_err;

   // Select fall seen while awake in idle: the start of a transfer.
   sequence s_sel_start;
      state == SSP_IDLE && cs_fall && !sleep_i;
   endsequence
   // Select rise seen while a transfer runs: the end of a frame.
   sequence s_sel_end;
      state == SSP_SHIFT && cs_rise;
   endsequence
   // Frame end with a length that must be refused.
   sequence s_bad_end;
      s_sel_end ##0 !len_ok;
   endsequence
   // Frame end with an accepted length.
   sequence s_good_end;
      s_sel_end ##0 len_ok;
   endsequence

   // A valid update never occurs while the frame length is bad.
   chk_bad_len_drop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_SHIFT && cs_rise && !len_ok) |=> (!frame_valid_o && transmission_error_flag_o))
      else $error("bad length frame was accepted");
   chk_good_len_take: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_SHIFT && cs_rise && len_ok) |=> (frame_valid_o && frame_data_o == $past(shreg)))
      else $error("valid frame not copied");
   chk_len_rule: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      frame_valid_o |-> ($past(cnt) >= 16 && $past(cnt[2:0]) == 3'h0))
      else $error("frame accepted with wrong count");
   chk_idle_float: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cs_s && state != SSP_SHIFT) |=> !so_oe_o)
      else $error("output driven while deselected");
   chk_sleep_float: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_IDLE && cs_fall && sleep_i) |=> (!so_oe_o && !resp_load_o))
      else $error("transfer in sleep");
   chk_first_bit_or: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_IDLE && cs_fall && !sleep_i) |=> (so_o == ($past(tx_err) | $past(si_s)) && resp_load_o))
      else $error("first output bit wrong");
   chk_shift_in: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_SHIFT && !cs_rise && sck_fall) |=> (shreg[0] == $past(si_s) && cnt == $past(cnt) + 1'b1))
      else $error("shift in failed");
   chk_shift_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_SHIFT && !cs_rise && sck_rise) |=> (so_o == $past(shreg[15])))
      else $error("shift out failed");
   chk_reset_resp: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (first && state == SSP_IDLE && cs_fall && !sleep_i) |=> (shreg == SSP_FIRST_RESP))
      else $error("first response wrong");
   // A started transfer drives the output in the next cycle.
   chk_start_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_sel_start |=> (so_oe_o && state == SSP_SHIFT))
      else $error("transfer did not start");
   // The end of a frame releases the output in the next cycle.
   chk_end_float: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_sel_end |=> !so_oe_o)
      else $error("output not released at frame end");
   // A refused frame raises the error pulse.
   chk_err_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_bad_end |=> frame_error_o)
      else $error("error pulse missing");
   // An accepted frame clears the error flag and raises no error pulse.
   chk_flag_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      s_good_end |=> (!transmission_error_flag_o && !frame_error_o))
      else $error("error flag not cleared");
   // Received data stands until the next accepted frame.
   chk_data_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !frame_valid_o |-> $stable(frame_data_o))
      else $error("received data changed");
   // A sleeping port neither shifts nor counts.
   chk_sleep_still: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == SSP_SLEEP) |=> ($stable(shreg) && $stable(cnt) && !so_oe_o))
      else $error("shift during sleep");
   // A software reset makes the next transfer send the fixed word.
   chk_soft_first: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      sw_reset_i |=> first)
      else $error("soft reset not taken");
endmodule // ssp_frame_port
`default_nettype wire

// ### verification/ssp_master_model.sv
/* Master model for the frame port bench: drives select, shift clock and serial in.
   Assumes the bench calls xfer and wires the pins straight to the port. */
`timescale 1ns/1ps
`default_nettype none
module ssp_master_model (
   output logic cs_n_o,
   output logic sclk_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic oe_i
);
   logic prev = 1'b0; // Last level read from the data-out line.
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end
   // A released line reads as the inverse of its last level.
   function automatic logic line();
      prev = oe_i ? so_i : ~prev;
      return prev;
   endfunction
   // One frame of n bits: MSB first, clock low at select edges, select raised at the end.
   task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] got,
                       output logic first);
      got = '0;
      #3 si_o = w[n-1];
      #100 cs_n_o = 1'b0;
      #200 first = line();
      for (int i = n - 1; i >= 0; i--) begin
         si_o = w[i];
         #25 sclk_o = 1'b1;
         #100 sclk_o = 1'b0;
         got = {got[30:0], line()};
         #75;
      end
      #125 cs_n_o = 1'b1;
      #300;
   endtask
endmodule // ssp_master_model
`default_nettype wire

// ### verification/ssp_frame_port_tb_top.sv
/* Self-checking bench for the frame port.
   Assumes the master model in its own file and the package constants. */
`timescale 1ns/1ps
`default_nettype none
module ssp_frame_port_tb_top
   import ssp_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sleep_i = 1'b0;
   logic sw_reset_i = 1'b0;
   logic [15:0] resp_word_i = 16'h3C5A;
   wire logic cs_n, sclk, si;
   logic so, so_oe, valid, error, load, err_flag;
   logic [15:0] frame_data;
   logic [31:0] got;
   logic first;
   logic oe_seen = 1'b0;
   int err_total = 0;
   int num_checks = 0;
   int n_valid = 0;
   int n_error = 0;
   int n_load = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   // Count the one-cycle pulses so frames can be judged after they end.
   always @(negedge ref_clk_i) begin
      n_valid += valid;
      n_error += error;
      n_load += load;
      if (so_oe === 1'b1) oe_seen = 1'b1;
   end
   ssp_frame_port dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .chip_select_low_i(cs_n),
      .sclk_i(sclk), .si_i(si), .sleep_i(sleep_i), .resp_word_i(resp_word_i), .sw_reset_i(sw_reset_i),
      .so_o(so), .so_oe_o(so_oe), .frame_data_o(frame_data), .frame_valid_o(valid),
      .frame_error_o(error), .resp_load_o(load), .transmission_error_flag_o(err_flag));
   ssp_master_model m (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so), .oe_i(so_oe));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Sends a frame and judges the pulse counts it produced.
   task automatic frame(input int n, input logic [31:0] w, input int dv, input int de);
      int v0;
      int e0;
      v0 = n_valid;
      e0 = n_error;
      @(negedge ref_clk_i);
      m.xfer(n, w, got, first);
      check("valid pulses", n_valid - v0, dv);
      check("error pulses", n_error - e0, de);
      check("idle enable", so_oe, 1'b0);
   endtask
   task automatic t_first();
      int l0;
      check("reset data", frame_data, 16'h0000);
      check("reset flag", err_flag, SSP_TXERR_RST);
      l0 = n_load;
      frame(16, 32'hA5C3, 1, 0);
      check("load pulses", n_load - l0, 1);
      check("first response", got[15:0], SSP_FIRST_RESP);
      check("rx word", frame_data, 16'hA5C3);
      frame(16, 32'h0F0F, 1, 0);
      check("response", got[15:0], resp_word_i);
      check("first bit", first, 1'b0);
      check("rx word 2", frame_data, 16'h0F0F);
      $display("test first done");
   endtask
   // Lengths that must be refused or accepted, with the flag and daisy bits.
   task automatic t_lengths();
      int lens[5] = '{8, 17, 24, 23, 32};
      logic [31:0] w;
      logic tb;
      w = 32'hB1E2_7D4C;
      foreach (lens[i]) begin
         tb = err_flag;
         frame(lens[i], w, (lens[i] >= 16 && lens[i] % 8 == 0), !(lens[i] >= 16 && lens[i] % 8 == 0));
         check("flag", err_flag, !(lens[i] >= 16 && lens[i] % 8 == 0));
         check("or bit", first, tb | w[lens[i]-1]);
         if (lens[i] == 24) check("daisy", got[7:0], w[23:16]);
         if (lens[i] == 17) check("kept", frame_data, 16'h0F0F);
         if (lens[i] >= 16 && lens[i] % 8 == 0) check("tail", frame_data, w[15:0]);
         if (lens[i] == 8) check("short kept", frame_data, 16'h0F0F);
      end
      $display("test lengths done");
   endtask
   task automatic t_sleep();
      @(negedge ref_clk_i) sleep_i = 1'b1;
      oe_seen = 1'b0;
      frame(16, 32'h1234, 0, 0);
      check("sleep enable", oe_seen, 1'b0);
      check("sleep data", frame_data, 16'h7D4C);
      @(negedge ref_clk_i) sleep_i = 1'b0;
      @(negedge ref_clk_i) sw_reset_i = 1'b1;
      @(negedge ref_clk_i) sw_reset_i = 1'b0;
      frame(16, 32'h5555, 1, 0);
      check("soft reset resp", got[15:0], SSP_FIRST_RESP);
      $display("test sleep done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i) sys_rst_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      t_first();
      t_lengths();
      t_sleep();
      report_and_stop();
   end
endmodule // ssp_frame_port_tb_top
`default_nettype wire
